// ---- verilog/mlt_transceiver.sv ----
// Manchester line transceiver core with loop, qualifier and register slave
//
// Summary of operation
// - Receive loop runs sixteen slots per bit
// - Loop free-runs when quiet, locks on edge
// - Early, centre, late windows adjust next cell
// - Sample at quarter points, change means bit
// - Acquire only after two edges within bit
// - Encode and decode Manchester without controller help
// - Activity output low whenever line is busy and we are not sending
// - Activity output negated while we transmit
// - Mode low: own preamble send and recognise
// - Master reset inhibits outputs, transmit clock runs
// - Clear-to-send asserted just before data accepted
// - Both clocks derived from reference input
// - Bit rate scales with reference clock
`timescale 1ns/1ns
module mlt_transceiver
	import mlt_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_arst_n,
	// Pins
	input  wire logic        i_ref_clock_in,        // Reference, 16x bit rate
	input  wire logic        i_master_reset_n,      // Transceiver master reset
	input  wire logic        i_mode,                // Low: own preamble
	input  wire logic        i_line_receive_pos,    // Line receiver, positive leg
	input  wire logic        i_line_receive_neg,    // Line receiver, negative leg
	output logic             o_line_tx_pos,         // Line driver, positive leg
	output logic             o_line_tx_neg,         // Line driver, negative leg
	output logic             o_line_tx_oe,          // Line driver enable
	// Controller side
	input  wire logic        i_rts_n,               // Request to send
	input  wire logic        i_txd,                 // Transmit data
	output logic             o_txc,                 // Transmit clock
	output logic             o_cts_n,               // Clear to send
	output logic             o_rxd,                 // Receive data
	output logic             o_rxc,                 // Receive clock
	output logic             o_carrier_n,           // Carrier sense
	output logic             o_line_activity_n,     // Line activity
	// Avalon-MM slave
	input  wire logic [3:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest
);
	typedef enum {TX_IDLE, TX_PRE, TX_DATA} mlt_tx_state_t;
	typedef enum {RX_HUNT, RX_DELIVER} mlt_rx_state_t;

	// Slot within window range
	function automatic logic in_win(input logic [3:0] s, input logic [3:0] lo,
		input logic [3:0] hi);
		in_win = (s >= lo) && (s <= hi);
	endfunction

	// Input synchronisers, stage one read only by stage two
	logic [2:0] ref_sync;      // Reference clock, third stage for edge
	logic [2:0] rxp_sync;      // Positive leg, third stage for edge
	logic [2:0] rxn_sync;      // Negative leg, third stage for edge
	logic [1:0] rts_sync;      // Request to send
	logic [1:0] txd_sync;      // Transmit data
	logic [1:0] mode_sync;     // Mode pin
	logic [1:0] mrst_sync;     // Master reset, internal state
	logic       slot_tick;     // One 16x slot elapsed
	logic       line_edge;     // Transition seen on the line
	logic       line_level;    // Synchronised line level
	logic       rts_n;
	logic       txd;
	logic       mode;
	logic       mrst;          // Internal state held in reset

	// Two-flop synchronisers and edge stages
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			ref_sync  <= '0;
			rxp_sync  <= '0;
			rxn_sync  <= '0;
			rts_sync  <= 2'h3;
			txd_sync  <= 2'h3;
			mode_sync <= '0;
			mrst_sync <= '0;
		end
		else
		begin
			ref_sync  <= {ref_sync[1:0], i_ref_clock_in};
			rxp_sync  <= {rxp_sync[1:0], i_line_receive_pos};
			rxn_sync  <= {rxn_sync[1:0], i_line_receive_neg};
			rts_sync  <= {rts_sync[0], i_rts_n};
			txd_sync  <= {txd_sync[0], i_txd};
			mode_sync <= {mode_sync[0], i_mode};
			mrst_sync <= {mrst_sync[0], i_master_reset_n};
		end
	end

	assign slot_tick  = ref_sync[1] & ~ref_sync[2];
	assign line_edge  = (rxp_sync[1] & ~rxn_sync[1]) ^ (rxp_sync[2] & ~rxn_sync[2]);
	assign line_level = rxp_sync[1] & ~rxn_sync[1];
	assign rts_n      = rts_sync[1];
	assign txd        = txd_sync[1];
	assign mode       = mode_sync[1];
	assign mrst       = ~mrst_sync[1];

	// Transmit side state
	logic [3:0]    tx_slot;    // Transmit slot counter
	mlt_tx_state_t tx_state;
	logic [3:0]    pre_idx;    // Preamble bit index
	logic          tx_bit;     // Bit of current cell
	logic          tx_level;   // Encoded line level
	logic          tx_busy;

	assign tx_busy = (tx_state != TX_IDLE);

	// Transmit clock divider, free of master reset
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			tx_slot <= '0;
		else if (slot_tick)
			tx_slot <= tx_slot + 4'h1;
	end

	// Transmit sequencer and Manchester encoder
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			tx_state <= TX_IDLE;
			pre_idx  <= '0;
			tx_bit   <= 1'b0;
			tx_level <= 1'b0;
		end
		else if (mrst)
		begin
			tx_state <= TX_IDLE;
			pre_idx  <= '0;
			tx_level <= 1'b0;
		end
		else if (slot_tick && tx_slot == SLOT_LAST)
		begin
			// Cell start: pick next bit, first half is its inverse
			unique case (tx_state)
				TX_IDLE:
				begin
					if (!rts_n && !mode)
					begin
						tx_state <= TX_PRE;
						pre_idx  <= '0;
						tx_bit   <= PREAMBLE[15];
						tx_level <= ~PREAMBLE[15];
					end
					else if (!rts_n)
					begin
						tx_state <= TX_DATA;
						tx_bit   <= txd;
						tx_level <= ~txd;
					end
				end
				TX_PRE:
				begin
					if (pre_idx == PRE_LAST)
					begin
						tx_state <= TX_DATA;
						tx_bit   <= txd;
						tx_level <= ~txd;
					end
					else
					begin
						pre_idx  <= pre_idx + 4'h1;
						tx_bit   <= PREAMBLE[4'hf - (pre_idx + 4'h1)];
						tx_level <= ~PREAMBLE[4'hf - (pre_idx + 4'h1)];
					end
				end
				TX_DATA:
				begin
					if (rts_n)
						tx_state <= TX_IDLE;
					else
					begin
						tx_bit   <= txd;
						tx_level <= ~txd;
					end
				end
			endcase
		end
		else if (slot_tick && tx_slot == (SLOT_MID - 4'h1))
			tx_level <= tx_bit;
	end

	// Receive loop state
	logic [3:0]    rx_slot;     // Receive slot counter
	logic [3:0]    next_rx_slot;
	logic          edge_pend;   // Edge waiting for next slot
	logic          edge_now;    // Edge within this slot
	logic [4:0]    gap;         // Slots since last edge
	logic          armed;       // One edge seen by qualifier
	logic          acquired;    // Receive clock acquired
	logic          activity;    // Line busy
	mlt_adj_t      adj;         // Pending adjustment
	mlt_adj_t      last_adj;    // Reported adjustment
	logic          early_smp;   // Quarter-point sample
	logic          bit_valid;   // Decoded bit strobe
	logic          bit_val;     // Decoded bit value
	logic          rx_wrap;     // Receive cell boundary

	assign edge_now = edge_pend | line_edge;

	// Next slot with window adjustment applied at cell end
	always_comb
	begin
		next_rx_slot = rx_slot + 4'h1;
		if (rx_slot == SLOT_LAST && acquired)
		begin
			if (adj == ADJ_SHORTEN)
				next_rx_slot = 4'h1;
			else if (adj == ADJ_LENGTHEN)
				next_rx_slot = SLOT_LAST;
		end
	end

	assign rx_wrap = slot_tick && (next_rx_slot < rx_slot);

	// Edge latch between slots, cleared as a tick consumes it
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			edge_pend <= 1'b0;
		else
			edge_pend <= (line_edge | edge_pend) & ~slot_tick;
	end

	// Qualifier, activity and loop phase
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			rx_slot   <= '0;
			gap       <= '0;
			armed     <= 1'b0;
			acquired  <= 1'b0;
			activity  <= 1'b0;
			adj       <= ADJ_CENTRE;
			last_adj  <= ADJ_CENTRE;
		end
		else if (mrst)
		begin
			gap      <= '0;
			armed    <= 1'b0;
			acquired <= 1'b0;
			activity <= 1'b0;
			adj      <= ADJ_CENTRE;
			rx_slot  <= rx_slot + 4'(slot_tick);
		end
		else if (slot_tick)
		begin
			rx_slot <= next_rx_slot;
			if (rx_slot == SLOT_LAST && adj != ADJ_CENTRE)
			begin
				last_adj <= adj;
				adj      <= ADJ_CENTRE;
			end
			if (edge_now)
			begin
				gap      <= '0;
				activity <= 1'b1;
				if (!acquired && armed && gap < QUAL_GAP)
				begin
					acquired <= 1'b1;
					rx_slot  <= SLOT_MID + 4'h1;
				end
				else if (!acquired)
					armed <= 1'b1;
				else if (in_win(rx_slot, WIN_EARLY_LO, WIN_EARLY_HI))
					adj <= ADJ_SHORTEN;
				else if (rx_slot == SLOT_MID)
					adj <= ADJ_CENTRE;
				else if (in_win(rx_slot, WIN_LATE_LO, WIN_LATE_HI))
					adj <= ADJ_LENGTHEN;
			end
			else if (gap >= QUIET_SLOTS)
			begin
				activity <= 1'b0;
				acquired <= 1'b0;
				armed    <= 1'b0;
			end
			else
			begin
				gap <= gap + 5'h1;
				if (gap >= QUAL_GAP && !acquired)
					armed <= 1'b0;
			end
		end
	end

	// Quarter-point sampling and Manchester decode
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			early_smp <= 1'b0;
			bit_valid <= 1'b0;
			bit_val   <= 1'b0;
		end
		else
		begin
			bit_valid <= 1'b0;
			if (slot_tick && acquired && !mrst)
			begin
				if (rx_slot == SLOT_QTR)
					early_smp <= line_level;
				if (rx_slot == SLOT_3QTR && line_level != early_smp)
				begin
					bit_valid <= 1'b1;
					bit_val   <= line_level;
				end
			end
		end
	end

	// Receive framing and FIFO feed
	mlt_rx_state_t rx_state;
	logic          prev_one;    // Previous decoded bit was one
	logic          push;        // Bit offered to FIFO
	logic          fifo_ready;
	logic          fifo_valid;
	logic          fifo_data;
	logic [3:0]    fifo_level;
	logic          rx_hold;     // Software stall of drain
	logic          pop;

	assign push = bit_valid && (rx_state == RX_DELIVER);

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			rx_state <= RX_HUNT;
			prev_one <= 1'b0;
		end
		else if (!acquired || mrst)
		begin
			rx_state <= mode ? RX_DELIVER : RX_HUNT;
			prev_one <= 1'b0;
		end
		else if (bit_valid)
		begin
			prev_one <= bit_val;
			if (rx_state == RX_HUNT && prev_one && bit_val)
				rx_state <= RX_DELIVER;
		end
	end

	assign pop = rx_wrap && !rx_hold && fifo_valid && !mrst;

	mlt_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.i_clk_sys   (i_clk_sys),
		.i_arst_n    (i_arst_n),
		.i_flush     (mrst),
		.i_in_valid  (push),
		.o_in_ready  (fifo_ready),
		.i_in_data   (bit_val),
		.o_out_valid (fifo_valid),
		.i_out_ready (pop),
		.o_out_data  (fifo_data),
		.o_level     (fifo_level)
	);

	// Receive data launched at receive clock rise
	logic rxd_q;
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			rxd_q <= 1'b1;
		else if (pop)
			rxd_q <= fifo_data;
	end

	// Register file
	logic        overrun;       // Sticky overflow
	logic [31:0] bit_count;     // Decoded bits delivered
	logic        ack;           // Answer cycle
	logic        wr_status;

	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;
	assign wr_status = i_avs_write && ack && i_avs_address == REG_STATUS
		&& i_avs_byteenable[0] && i_avs_writedata[ST_OVERRUN];

	// Bus answer one cycle after request
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			ack <= 1'b0;
		else
			ack <= (i_avs_read | i_avs_write) & ~ack;
	end

	// Control register write
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			rx_hold <= CTRL_RESET[CTRL_RX_HOLD];
		else if (i_avs_write && ack && i_avs_address == REG_CTRL && i_avs_byteenable[0])
			rx_hold <= i_avs_writedata[CTRL_RX_HOLD];
	end

	// Overrun flag, set wins over clear
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			overrun <= 1'b0;
		else if (push && !fifo_ready)
			overrun <= 1'b1;
		else if (wr_status)
			overrun <= 1'b0;
	end

	// Delivered bit counter
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			bit_count <= '0;
		else if (push && fifo_ready)
			bit_count <= bit_count + 32'h1;
	end

	// Read data, unmapped reads zero
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			o_avs_readdata <= '0;
		else if (i_avs_read && !ack)
		begin
			o_avs_readdata <= '0;
			unique case (i_avs_address)
				REG_CTRL:
					o_avs_readdata[CTRL_RX_HOLD] <= rx_hold;
				REG_STATUS:
				begin
					o_avs_readdata[ST_CARRIER]                  <= acquired;
					o_avs_readdata[ST_ACTIVITY]                 <= activity;
					o_avs_readdata[ST_TX_BUSY]                  <= tx_busy;
					o_avs_readdata[ST_OVERRUN]                  <= overrun;
					o_avs_readdata[ST_ADJ_LO +: 2]              <= last_adj;
					o_avs_readdata[ST_LEVEL_LO +: 4]            <= fifo_level;
				end
				REG_BITCNT:
					o_avs_readdata <= bit_count;
				default:
					o_avs_readdata <= '0;
			endcase
		end
	end

	// Pin outputs, master reset gates all but transmit clock
	assign o_txc             = (tx_slot < SLOT_MID);
	assign o_line_tx_pos     = i_master_reset_n & tx_busy & tx_level;
	assign o_line_tx_neg     = i_master_reset_n & tx_busy & ~tx_level;
	assign o_line_tx_oe      = i_master_reset_n & tx_busy;
	assign o_cts_n           = ~(i_master_reset_n & ((tx_state == TX_DATA)
		| (tx_state == TX_PRE && pre_idx >= PRE_CTS)
		| (tx_state == TX_IDLE && mode && !rts_n)));
	assign o_rxd             = ~i_master_reset_n | rxd_q;
	assign o_rxc             = i_master_reset_n & (rx_slot < SLOT_MID);
	assign o_carrier_n       = ~(i_master_reset_n & acquired);
	assign o_line_activity_n = ~(i_master_reset_n & activity & ~tx_busy);
endmodule // mlt_transceiver

// ---- verilog/mlt_pkg.sv ----
// Shared constants of the Manchester line transceiver logic
package mlt_pkg;

	// Bit cell timing, in reference-clock slots
	localparam int          SLOTS_PER_BIT = 16;             // Loop rate over data rate
	localparam logic [3:0]  SLOT_LAST     = 4'hf;           // Last slot of a cell
	localparam logic [3:0]  SLOT_QTR      = 4'h4;           // First data sample
	localparam logic [3:0]  SLOT_MID      = 4'h8;           // Nominal mid-cell transition
	localparam logic [3:0]  SLOT_3QTR     = 4'hc;           // Second data sample
	localparam logic [3:0]  WIN_EARLY_LO  = 4'h5;           // Early window start
	localparam logic [3:0]  WIN_EARLY_HI  = 4'h7;           // Early window end
	localparam logic [3:0]  WIN_LATE_LO   = 4'h9;           // Late window start
	localparam logic [3:0]  WIN_LATE_HI   = 4'hb;           // Late window end
	localparam logic [4:0]  QUAL_GAP      = 5'h10;          // Two edges within one bit
	localparam logic [4:0]  QUIET_SLOTS   = 5'h18;          // Quiet time before release

	// Transmit preamble, sent MSB first, ends in two ones
	localparam logic [15:0] PREAMBLE      = 16'haaab;
	localparam logic [3:0]  PRE_LAST      = 4'hf;           // Index of last preamble bit
	localparam logic [3:0]  PRE_CTS       = 4'he;           // Clear-to-send lead point

	// Receive FIFO shape
	localparam int          FIFO_WIDTH    = 1;
	localparam int          FIFO_DEPTH    = 8;

	// Register byte offsets
	localparam logic [3:0]  REG_CTRL      = 4'h0;           // Control
	localparam logic [3:0]  REG_STATUS    = 4'h4;           // Status, write one to clear
	localparam logic [3:0]  REG_BITCNT    = 4'h8;           // Decoded bit count

	// Field positions
	localparam int          CTRL_RX_HOLD  = 0;              // Stall receive drain
	localparam int          ST_CARRIER    = 0;              // Receive clock acquired
	localparam int          ST_ACTIVITY   = 1;              // Line activity
	localparam int          ST_TX_BUSY    = 2;              // Transmitting
	localparam int          ST_OVERRUN    = 3;              // Sticky, FIFO overflow
	localparam int          ST_ADJ_LO     = 4;              // Last loop adjustment, 2 bits
	localparam int          ST_LEVEL_LO   = 8;              // FIFO level, 4 bits

	// Reset values
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

	// Loop adjustment codes
	typedef enum logic [1:0] {ADJ_CENTRE, ADJ_SHORTEN, ADJ_LENGTHEN} mlt_adj_t;

endpackage

// ---- verilog/mlt_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
module mlt_fifo
	import mlt_pkg::*;
#(
	parameter int WIDTH = FIFO_WIDTH,
	parameter int DEPTH = FIFO_DEPTH
)(
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_arst_n,
	input  wire logic                       i_flush,     // Synchronous empty
	input  wire logic                       i_in_valid,
	output logic                            o_in_ready,
	input  wire logic [WIDTH-1:0]           i_in_data,
	output logic                            o_out_valid,
	input  wire logic                       i_out_ready,
	output logic      [WIDTH-1:0]           o_out_data,
	output logic      [$clog2(DEPTH+1)-1:0] o_level
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem [DEPTH];   // Storage
	logic [AW-1:0]    wr_ptr;        // Write index
	logic [AW-1:0]    rd_ptr;        // Read index
	logic [CW-1:0]    count;         // Words held
	logic             push;
	logic             pop;

	assign o_in_ready  = (count != CW'(DEPTH));
	assign o_out_valid = (count != '0);
	assign o_out_data  = mem[rd_ptr];
	assign o_level     = count;
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	// Storage write
	always_ff @(posedge i_clk_sys)
	begin
		if (push)
			mem[wr_ptr] <= i_in_data;
	end

	// Pointers and count
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else if (i_flush)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			count <= count + CW'(push) - CW'(pop);
		end
	end
endmodule // mlt_fifo

// ---- tb/mlt_transceiver_assertions.sv ----
// Port checks of the transceiver core, bound into it
`timescale 1ns/1ns
module mlt_transceiver_assertions
	import mlt_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	input wire logic i_master_reset_n,
	input wire logic i_mode,
	input wire logic i_line_receive_pos,
	input wire logic i_line_receive_neg,
	input wire logic o_line_tx_pos,
	input wire logic o_line_tx_neg,
	input wire logic o_line_tx_oe,
	input wire logic o_txc,
	input wire logic o_cts_n,
	input wire logic o_rxd,
	input wire logic o_rxc,
	input wire logic o_carrier_n,
	input wire logic o_line_activity_n,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic o_avs_waitrequest
);
	logic [8:0] gap;   // Cycles since transmit clock rose
	logic [8:0] quiet; // Cycles since line level moved
	logic       lvl_q; // Line level a cycle ago
	logic       mr_q;  // Master reset a cycle ago
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);
	// Saturating counters, gap at top value means not yet known
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
		if (!i_arst_n)
		begin
			gap   <= 9'h1ff;
			quiet <= 9'h000;
			lvl_q <= 1'b0;
			mr_q  <= 1'b0;
		end
		else
		begin
			mr_q  <= i_master_reset_n;
			lvl_q <= i_line_receive_pos & ~i_line_receive_neg;
			if ($rose(o_txc))
				gap <= 9'h001;
			else if (gap != 9'h1ff)
				gap <= gap + 9'h001;
			if ((i_line_receive_pos & ~i_line_receive_neg) != lvl_q)
				quiet <= 9'h000;
			else if (quiet != 9'h1ff)
				quiet <= quiet + 9'h001;
		end
	a_mreset_inhibit: assert property (!i_master_reset_n |-> !o_line_tx_oe && o_cts_n
		&& o_rxd && o_carrier_n && o_line_activity_n) else $error("Outputs live in reset");
	a_txc_period: assert property ($rose(o_txc) && gap != 9'h1ff
		|-> gap inside {[9'd255:9'd257]}) else $error("Transmit clock period wrong");
	a_tx_hides_act: assert property (o_line_tx_oe |-> o_line_activity_n)
		else $error("Activity shown while sending");
	a_carrier_act: assert property (!o_carrier_n && !o_line_tx_oe |-> !o_line_activity_n)
		else $error("Carrier without activity");
	a_acquire_edge: assert property ($fell(o_carrier_n) && mr_q |-> quiet < 9'd40)
		else $error("Carrier not tied to a line edge");
	a_act_release: assert property ($rose(o_line_activity_n) && i_master_reset_n && mr_q
		&& !o_line_tx_oe && !$past(o_line_tx_oe) |-> quiet >= 9'd256)
		else $error("Activity released too early");
	a_cts_drive: assert property (!o_cts_n |-> o_line_tx_oe || i_mode)
		else $error("Clear to send without driving");
	a_leg_compl: assert property (o_line_tx_oe |-> o_line_tx_neg != o_line_tx_pos)
		else $error("Line legs not complementary");
	a_pre_lead: assert property ($fell(o_cts_n) && !i_mode |-> $past(o_line_tx_oe, 200))
		else $error("Clear to send before preamble");
	a_mid_change: assert property ($fell(o_txc) && o_line_tx_oe && $past(o_line_tx_oe, 4)
		|-> ##[0:3] (o_line_tx_pos != $past(o_line_tx_pos, 4))) else $error("No mid-cell change");
	a_rxd_wrap: assert property ($changed(o_rxd) && i_master_reset_n && mr_q |-> $rose(o_rxc))
		else $error("Receive data moved off cell wrap");
	a_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
		|=> !o_avs_waitrequest) else $error("Wait state count wrong");
	c_acquire: cover property ($fell(o_carrier_n));
	c_preamble: cover property ($fell(o_cts_n) && !i_mode);
	c_release: cover property ($rose(o_line_activity_n));
endmodule // mlt_transceiver_assertions
bind mlt_transceiver mlt_transceiver_assertions mlt_transceiver_assertions_i (.*);

// ---- tb/mlt_ctrl_model.sv ----
// Behavioural serial controller facing the modem-style pins
`timescale 1ns/1ns
module mlt_ctrl_model
	import mlt_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_arst_n,
	input  wire logic        i_send,            // Wish to transmit
	input  wire logic        i_tx_bit,          // Next data bit
	input  wire logic        i_txc,
	input  wire logic        i_rxd,
	input  wire logic        i_rxc,
	input  wire logic        i_line_activity_n,
	output logic             o_rts_n,
	output logic             o_txd,
	output logic             o_dreq_n,          // DMA request
	output logic      [31:0] o_rx_hist          // Captured receive bits
);
	// Send request gated by activity, data launched per cell
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
		if (!i_arst_n)
		begin
			o_rts_n <= 1'b1;
			o_txd   <= 1'b1;
		end
		else
		begin
			o_rts_n <= ~i_send | ~i_line_activity_n;
			if ($rose(i_txc))
				o_txd <= i_tx_bit;
		end
	// Capture on the inverted receive clock, so data has settled
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
		if (!i_arst_n)
		begin
			o_dreq_n  <= 1'b1;
			o_rx_hist <= 32'h0;
		end
		else
		begin
			o_dreq_n <= ~($rose(i_txc) | $fell(i_rxc));
			if ($fell(i_rxc))
				o_rx_hist <= {o_rx_hist[30:0], i_rxd};
		end
endmodule // mlt_ctrl_model

// ---- tb/tb_mlt_transceiver.sv ----
// Self-checking bench of the transceiver with a controller model
`timescale 1ns/1ns
module tb_mlt_transceiver
	import mlt_pkg::*;
;
	logic        i_clk_sys          = 1'b0;
	logic        i_arst_n           = 1'b0;
	logic        i_ref_clock_in     = 1'b0; // Reference, 16 slots a bit
	logic        i_master_reset_n   = 1'b1;
	logic        i_mode             = 1'b1;
	logic        i_line_receive_pos = 1'b0; // Idle line, both legs low
	logic        i_line_receive_neg = 1'b0;
	logic [3:0]  i_avs_address      = 4'h0;
	logic        i_avs_read         = 1'b0;
	logic        i_avs_write        = 1'b0;
	logic [31:0] i_avs_writedata    = 32'h0;
	logic [3:0]  i_avs_byteenable   = 4'hf;
	logic        send               = 1'b0; // Controller wants to send
	logic        tx_bit             = 1'b0; // Controller data bit
	logic [31:0] rdata;                     // Last read word
	logic [31:0] tx_hist            = '0;   // Bits seen on the driven line
	logic        seen_car           = 1'b0; // Carrier and activity seen
	wire         i_rts_n, i_txd, o_line_tx_pos, o_line_tx_neg, o_line_tx_oe, o_txc, o_cts_n;
	wire         o_rxd, o_rxc, o_carrier_n, o_line_activity_n, o_avs_waitrequest, dreq_n;
	wire  [31:0] o_avs_readdata, rx_hist;
	int          err_total = 0, tests_run = 0, tx_n = 0, mon = 0, rises = 0, k;
	always #2 i_clk_sys = ~i_clk_sys;
	always #32 i_ref_clock_in = ~i_ref_clock_in;
	mlt_transceiver mlt_transceiver_i (.*);
	mlt_ctrl_model mlt_ctrl_model_i (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_send(send),
		.i_tx_bit(tx_bit), .i_txc(o_txc), .i_rxd(o_rxd), .i_rxc(o_rxc),
		.i_line_activity_n(o_line_activity_n), .o_rts_n(i_rts_n), .o_txd(i_txd),
		.o_dreq_n(dreq_n), .o_rx_hist(rx_hist));
	// Decode the driven line at three quarters of each cell
	always @(posedge i_clk_sys)
	begin
		mon <= $fell(o_txc) ? 0 : mon + 1;
		if ($rose(o_txc))
			rises <= rises + 1;
		if (mon == 64 && o_line_tx_oe === 1'b1)
		begin
			tx_hist <= {tx_hist[30:0], o_line_tx_pos};
			tx_n    <= tx_n + 1;
		end
		if (o_carrier_n === 1'b0 && o_line_activity_n === 1'b0)
			seen_car <= 1'b1;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One bus transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_avs_address   <= a;
		i_avs_writedata <= d;
		i_avs_read      <= ~w;
		i_avs_write     <= w;
		do
			@(posedge i_clk_sys);
		while (o_avs_waitrequest !== 1'b0);
		rdata = o_avs_readdata;
		i_avs_read  <= 1'b0;
		i_avs_write <= 1'b0;
	endtask
	// Manchester frame on the line, MSB first, complement then bit
	task automatic line(input logic [31:0] bits, input int n);
		for (int i = n - 1; i >= 0; i--)
			for (int h = 0; h < 2; h++)
			begin
				i_line_receive_pos <= bits[i] ~^ h[0];
				i_line_receive_neg <= ~(bits[i] ~^ h[0]);
				repeat (128) @(posedge i_clk_sys);
			end
		i_line_receive_pos <= 1'b0;
		i_line_receive_neg <= 1'b0;
	endtask
	task automatic close_out;
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge i_clk_sys);
		i_arst_n <= 1'b1;
		@(posedge i_clk_sys);
		chk(32'({o_line_tx_oe, o_cts_n, o_rxd, o_carrier_n, o_line_activity_n}), 32'h0f);
		bus(1'b0, REG_CTRL, 32'h0);
		chk(rdata, CTRL_RESET);
		bus(1'b0, 4'hc, 32'h0);
		chk(rdata, 32'h0);
		bus(1'b1, REG_CTRL, 32'h1);
		i_avs_byteenable <= 4'h0;
		bus(1'b1, REG_CTRL, 32'h0);
		i_avs_byteenable <= 4'hf;
		bus(1'b0, REG_CTRL, 32'h0);
		chk(rdata, 32'h1);
		$display("Test registers done");
		// Receive into a held FIFO until it overflows, then drain
		i_mode <= 1'b0;
		line(32'haaab_5ca3, 32);
		while (o_line_activity_n !== 1'b1)
			@(posedge i_clk_sys);
		chk(32'(seen_car), 32'h1);
		bus(1'b0, REG_STATUS, 32'h0);
		chk(rdata & 32'h0f0b, 32'h0808);
		bus(1'b1, REG_STATUS, 32'h8);
		bus(1'b0, REG_STATUS, 32'h0);
		chk(rdata & 32'h0f08, 32'h0800);
		bus(1'b1, REG_CTRL, 32'h0);
		repeat (2600) @(posedge i_clk_sys);
		bus(1'b0, REG_STATUS, 32'h0);
		chk(rdata & 32'h0f00, 32'h0);
		k = 0;
		for (int i = 0; i < 25; i++)
			if (rx_hist[i+:8] == 8'h5c)
				k = 1;
		chk(32'(k), 32'h1);
		$display("Test receive done");
		// Send with own preamble, then master reset mid-frame
		send <= 1'b1;
		while (tx_n < 20)
			@(posedge i_clk_sys);
		chk(32'(tx_hist[19:0]), 32'({PREAMBLE, 4'h0}));
		chk(32'(o_cts_n), 32'h0);
		i_master_reset_n <= 1'b0;
		@(posedge i_clk_sys);
		#1;
		chk(32'({o_line_tx_oe, o_cts_n, o_rxd, o_carrier_n, o_line_activity_n}), 32'h0f);
		k = rises;
		repeat (600) @(posedge i_clk_sys);
		chk(32'(rises - k >= 2), 32'h1);
		i_master_reset_n <= 1'b1;
		send             <= 1'b0;
		i_mode           <= 1'b1;
		repeat (600) @(posedge i_clk_sys);
		chk(32'(o_line_tx_oe), 32'h0);
		$display("Test preamble send done");
		// Send without preamble, data straight from the controller
		tx_bit <= 1'b1;
		send   <= 1'b1;
		k = tx_n;
		while (tx_n < k + 5)
			@(posedge i_clk_sys);
		chk(32'(tx_hist[3:0]), 32'hf);
		chk(32'(o_cts_n), 32'h0);
		send <= 1'b0;
		while (o_line_tx_oe !== 1'b0)
			@(posedge i_clk_sys);
		chk(32'(o_cts_n), 32'h1);
		$display("Test plain send done");
		close_out();
	end
	// Watchdog against a hang
	initial
	begin
		repeat (40000) @(posedge i_clk_sys);
		err_total++;
		$display("Error at %0t: timeout", $time);
		close_out();
	end
endmodule // tb_mlt_transceiver
